// file: design/girq_pkg.sv
// Package for the global interrupt and soft reset block: offsets, fields, carriers
package girq_pkg;

  // ==========================================================================
  // Byte offsets of the register window
  localparam logic [15:0] GIRQ_ADDR_REV_RST = 16'h0003;
  localparam logic [15:0] GIRQ_ADDR_PIN_CTL = 16'h0006;
  localparam logic [15:0] GIRQ_ADDR_GSTAT = 16'h0010;
  localparam logic [15:0] GIRQ_ADDR_GMASK = 16'h0014;
  localparam logic [15:0] GIRQ_ADDR_PSTAT = 16'h0018;
  localparam logic [15:0] GIRQ_ADDR_PMASK = 16'h001c;

  // ==========================================================================
  // Field positions
  localparam int GIRQ_BIT_SOFT_RST = 0;
  localparam int GIRQ_REV_LSB = 4;
  localparam int GIRQ_BIT_PIN_OE = 1;
  localparam int GIRQ_BIT_PIN_POL = 0;
  localparam int GIRQ_BIT_LOOKUP = 31;
  localparam int GIRQ_BIT_TRIG = 30;
  localparam int GIRQ_NUM_PORTS = 7;

  // ==========================================================================
  // Reset values
  localparam logic GIRQ_RST_BIT0 = 1'b0;
  localparam logic [1:0] GIRQ_RST_PIN_CTL = 2'h0;
  localparam logic [1:0] GIRQ_RST_GMASK = 2'h0;
  localparam logic [GIRQ_NUM_PORTS-1:0] GIRQ_RST_PMASK = 7'h00;
  localparam logic [3:0] GIRQ_DEF_REVISION = 4'h1; // Arbitrary value

  // ==========================================================================
  // Byte access carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } girq_req_s;

  // Lower-level interrupt sources
  typedef struct packed {
    logic lookup_engine;
    logic trig_unit;
    logic ts_unit;
    logic [GIRQ_NUM_PORTS-1:0] port;
  } girq_src_s;

endpackage

// file: design/girq_top.sv
// Global interrupt summary, soft reset and power-event pin control
// Operation
// - soft reset bit set holds datapath and state machines reset, registers kept
// - soft reset bit never self-clears; only a management write of 0 or rst_n low releases it
// - power-event pin driven only while pin output-enable bit 1 is set
// - pin control bit 0 picks polarity: 0 active low, 1 active high
// - global status bit 31 reads 1 while lookup engine requests interrupt
// - global status bit 30 reads trigger-output or timestamp unit request
// - per-port egress timestamp interrupts stay out of bit 30
// - global mask bit 31 disables lookup engine interrupt when 1
// - global mask bit 30 disables trigger/timestamp interrupt when 1
// - port summary status bits 0..6 show ports 1..7 requests
// - port summary mask bits 0..6 disable ports 1..7 when 1
// - each port summary bit follows that port's own detailed status
// - registers byte addressed big-endian, each byte accessed alone
`timescale 1ns/1ps
`default_nettype none
module girq_top
  import girq_pkg::*;
#(
  parameter logic [3:0] REVISION = GIRQ_DEF_REVISION
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Byte register access
  input wire girq_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Interrupt sources
  input wire girq_src_s src,
  // Outputs
  output logic datapath_rst,
  output logic irq_req,
  output logic power_event_pin_o,
  output logic power_event_pin_oe
);

  // ==========================================================================
  // Registers
  logic soft_rst_reg;
  logic [1:0] pin_ctl_reg;
  logic [1:0] gmask_reg;
  logic [GIRQ_NUM_PORTS-1:0] pmask_reg;
  logic [1:0] gstat_reg;
  logic [GIRQ_NUM_PORTS-1:0] pstat_reg;
  logic [31:0] gstat_w, gmask_w, pstat_w, pmask_w;
  logic [7:0] rd_next;
  logic irq_next;

  // Word views, used only for byte read selection; byte writes take req.wdata directly
  always_comb begin
    gstat_w = '0;
    gstat_w[GIRQ_BIT_LOOKUP] = gstat_reg[1];
    gstat_w[GIRQ_BIT_TRIG] = gstat_reg[0];
    gmask_w = '0;
    gmask_w[GIRQ_BIT_LOOKUP] = gmask_reg[1];
    gmask_w[GIRQ_BIT_TRIG] = gmask_reg[0];
    pstat_w = {25'h0, pstat_reg};
    pmask_w = {25'h0, pmask_reg};
  end

  // Picks the big-endian byte: lowest address holds bits 31:24
  function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] b;
    b = '0;
    case (lane)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      default: b = w[7:0];
    endcase
    return b;
  endfunction

  // ==========================================================================
  // Source sampling; pure levels, reads never clear them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gstat_reg <= 2'h0;
      pstat_reg <= '0;
    end else begin
      gstat_reg[1] <= src.lookup_engine;
      gstat_reg[0] <= src.trig_unit | src.ts_unit;
      pstat_reg <= src.port;
    end
  end

  // ==========================================================================
  // Byte writes; reserved bits are simply not stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_rst_reg <= GIRQ_RST_BIT0;
    end else if (req.wr && req.addr == GIRQ_ADDR_REV_RST) begin
      soft_rst_reg <= req.wdata[GIRQ_BIT_SOFT_RST];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_ctl_reg <= GIRQ_RST_PIN_CTL;
    end else if (req.wr && req.addr == GIRQ_ADDR_PIN_CTL) begin
      pin_ctl_reg <= {req.wdata[GIRQ_BIT_PIN_OE], req.wdata[GIRQ_BIT_PIN_POL]};
    end
  end

  // Mask bits 31 and 30 live in the first byte of the word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gmask_reg <= GIRQ_RST_GMASK;
    end else if (req.wr && req.addr == GIRQ_ADDR_GMASK) begin
      gmask_reg <= req.wdata[7:6];
    end
  end

  // Port mask bits live in the last byte of the word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pmask_reg <= GIRQ_RST_PMASK;
    end else if (req.wr && req.addr == (GIRQ_ADDR_PMASK | 16'h0003)) begin
      pmask_reg <= req.wdata[GIRQ_NUM_PORTS-1:0];
    end
  end

  // ==========================================================================
  // Byte reads, one cycle latency; unmapped bytes read zero
  always_comb begin
    rd_next = '0;
    case (req.addr & 16'hfffc)
      16'h0000: begin
        if (req.addr[1:0] == 2'h3) begin
          rd_next = '0;
          rd_next[7:GIRQ_REV_LSB] = REVISION;
          rd_next[GIRQ_BIT_SOFT_RST] = soft_rst_reg;
        end
      end
      16'h0004: begin
        if (req.addr[1:0] == 2'h2) begin
          rd_next = {6'h00, pin_ctl_reg};
        end
      end
      GIRQ_ADDR_GSTAT: rd_next = be_byte(gstat_w, req.addr[1:0]);
      GIRQ_ADDR_GMASK: rd_next = be_byte(gmask_w, req.addr[1:0]);
      GIRQ_ADDR_PSTAT: rd_next = be_byte(pstat_w, req.addr[1:0]);
      GIRQ_ADDR_PMASK: rd_next = be_byte(pmask_w, req.addr[1:0]);
      default: rd_next = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      rdata <= rd_next;
      rvalid <= req.rd;
    end
  end

  // ==========================================================================
  // Combined request and pin
  assign irq_next = |(gstat_reg & ~gmask_reg) | |(pstat_reg & ~pmask_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
      power_event_pin_o <= 1'b0;
      power_event_pin_oe <= 1'b0;
      datapath_rst <= 1'b0;
    end else begin
      irq_req <= irq_next;
      // Active low by default, so idle drives high
      power_event_pin_o <= irq_next ^ ~pin_ctl_reg[0];
      power_event_pin_oe <= pin_ctl_reg[1];
      // Register contents are untouched by this reset
      datapath_rst <= soft_rst_reg;
    end
  end

  // ==========================================================================
  // Checks
  sequence wr_soft(logic v);
    req.wr && req.addr == GIRQ_ADDR_REV_RST && req.wdata[GIRQ_BIT_SOFT_RST] == v;
  endsequence

  soft_rst_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_rst_reg && !req.wr |=> soft_rst_reg) else $error("soft reset cleared itself");
  soft_rst_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_soft(1'b1) ##1 1'b1 |=> datapath_rst) else $error("datapath reset not asserted");
  pin_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pin_ctl_reg[1] |=> !power_event_pin_oe) else $error("pin driven while disabled");
  pin_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> power_event_pin_o == (irq_req ~^ $past(pin_ctl_reg[0]))) else $error("pin polarity wrong");
  lookup_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    src.lookup_engine |=> gstat_reg[1]) else $error("lookup status missing");
  trig_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (src.trig_unit || src.ts_unit) |=> gstat_reg[0]) else $error("trigger status missing");
  port_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> pstat_reg == $past(src.port)) else $error("port status mismatch");
  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    gstat_reg[1] && !gmask_reg[1] |=> irq_req) else $error("unmasked request lost");
  pmask_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pstat_reg & ~pmask_reg) == '0 && (gstat_reg & ~gmask_reg) == '0 |=> !irq_req)
    else $error("masked request leaked");

  // Sampled reset in the pin_pol_a and port_stat_a antecedents keeps the release edge from checking reset values
  sequence rd_byte;
    req.rd;
  endsequence
  read_ans_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_byte |=> rvalid) else $error("read answer missing");
  read_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !req.rd |=> !rvalid) else $error("read answer without request");
  soft_rst_rel_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_soft(1'b0) ##1 1'b1 |=> !datapath_rst) else $error("datapath reset not released");
  trig_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    gstat_reg[0] && !gmask_reg[0] |=> irq_req) else $error("unmasked trigger request lost");
  port_unmask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pstat_reg & ~pmask_reg) != '0 |=> irq_req) else $error("unmasked port request lost");
  lookup_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    !src.lookup_engine |=> !gstat_reg[1]) else $error("lookup status stuck after source cleared");

endmodule
`default_nettype wire

// file: dv/girq_host.sv
// Management processor model issuing byte register accesses
`timescale 1ns/1ps
`default_nettype none
module girq_host
  import girq_pkg::*;
(
  // Clock
  input wire logic clk,
  // Byte register access
  output var girq_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // ==========================================================================
  // Byte cycles: one-cycle strobe, one byte per access
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) req <= '0;
    #1;
    while (rvalid !== 1'b1 && n < 3) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask
  // Mixed bytes are only ever updated by read, merge, write back
  task automatic rmw(input logic [15:0] a, input logic [7:0] set, input logic [7:0] clr);
    logic [7:0] v;
    rd(a, v);
    wr(a, (v & ~clr) | set);
  endtask
endmodule
`default_nettype wire

// file: dv/tb_global_interrupt_and_soft_reset.sv
// Self-checking bench for the global interrupt and soft reset block
`timescale 1ns/1ps
`default_nettype none
module tb_global_interrupt_and_soft_reset;
  import girq_pkg::*;
  localparam logic [3:0] REV = 4'ha;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  girq_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  girq_src_s src = '0;
  logic datapath_rst, irq_req, pin_o, pin_oe;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'hf747;
  logic [1:0] gm;
  logic [6:0] pm;
  logic oe, pol, exp_irq;
  always #10 clk = ~clk;
  girq_top #(.REVISION(REV)) girq_top_inst (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .rvalid(rvalid), .src(src), .datapath_rst(datapath_rst), .irq_req(irq_req),
    .power_event_pin_o(pin_o), .power_event_pin_oe(pin_oe));
  girq_host girq_host_inst (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    girq_host_inst.rd(a, v);
    chk8(e, v);
  endtask
  task automatic print_verdict;
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(GIRQ_ADDR_REV_RST, {REV, 4'h0});
    rdchk(GIRQ_ADDR_PIN_CTL, 8'h00);
    chk1(1'b0, pin_oe);
    for (int i = 0; i < 4; i++) begin
      rdchk(GIRQ_ADDR_GMASK + 16'(i), 8'h00);
      rdchk(GIRQ_ADDR_PMASK + 16'(i), 8'h00);
    end
    rdchk(16'h0020, 8'h00);
    // Soft reset must hold, keep registers, and release only on a written 0
    girq_host_inst.wr(GIRQ_ADDR_PMASK + 16'h3, 8'h55);
    girq_host_inst.rmw(GIRQ_ADDR_REV_RST, 8'h01, 8'h00);
    repeat (20) @(posedge clk);
    #1 chk1(1'b1, datapath_rst);
    rdchk(GIRQ_ADDR_REV_RST, {REV, 4'h1});
    rdchk(GIRQ_ADDR_PMASK + 16'h3, 8'h55);
    girq_host_inst.rmw(GIRQ_ADDR_REV_RST, 8'h00, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk1(1'b0, datapath_rst);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      gm = seed[1:0];
      pm = seed[8:2];
      {oe, pol} = seed[20:19];
      if (i == 0) {gm, pm, seed[18:9]} = '1;
      if (i == 1) {gm, pm, seed[18:9]} = 19'h00080;
      girq_host_inst.wr(GIRQ_ADDR_GMASK, {gm, 6'h00});
      girq_host_inst.wr(GIRQ_ADDR_PMASK + 16'h3, {1'b0, pm});
      girq_host_inst.rmw(GIRQ_ADDR_PIN_CTL, {6'h00, oe, pol}, 8'h03);
      @(posedge clk) src <= girq_src_s'(seed[18:9]);
      repeat (4) @(posedge clk);
      rdchk(GIRQ_ADDR_GSTAT, {src.lookup_engine, src.trig_unit | src.ts_unit, 6'h00});
      rdchk(GIRQ_ADDR_GSTAT + 16'h3, 8'h00);
      rdchk(GIRQ_ADDR_PSTAT + 16'h3, {1'b0, src.port});
      rdchk(GIRQ_ADDR_PSTAT + 16'h3, {1'b0, src.port});
      rdchk(GIRQ_ADDR_GMASK, {gm, 6'h00});
      rdchk(GIRQ_ADDR_PIN_CTL, {6'h00, oe, pol});
      exp_irq = (src.lookup_engine & ~gm[1]) | ((src.trig_unit | src.ts_unit) & ~gm[0]) | (|(src.port & ~pm));
      chk1(exp_irq, irq_req);
      chk1(oe, pin_oe);
      chk1(exp_irq ? pol : ~pol, pin_o);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
